// ===== rtl/fnsi_pkg.sv
// shared constants, types and timing for the fieldbus node state indicator
package fnsi_pkg;

   // system clock and the derived millisecond tick
   localparam int CLK_HZ = 200_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int MS_CNT_W = 18;

   // led pattern timing, in milliseconds of the tick
   localparam int FLICKER_PERIOD_MS = 100;   // 10 Hz
   localparam int FLICKER_ON_MS = 50;
   localparam int BLINK_PERIOD_MS = 400;     // 2.5 Hz
   localparam int BLINK_ON_MS = 200;
   localparam int FLASH_PERIOD_MS = 1000;    // 1 Hz
   localparam int FLASH_SLOT_MS = 300;
   localparam int FLASH_ON_MS = 150;

   // system stop error code timing, in milliseconds
   localparam int ERR_SHORT_MS = 150;
   localparam int ERR_LONG_MS = 600;
   localparam int ERR_GAP_MS = 300;
   localparam int ERR_PAUSE_MS = 2000;
   localparam int ERR_PHASES = 4;

   // counter widths
   localparam int POS_W = 12;
   localparam int TMO_W = 16;

   // green led patterns
   typedef enum logic [2:0] {
      PAT_OFF = 3'h0,
      PAT_ON = 3'h1,
      PAT_FLICKER = 3'h2,
      PAT_SINGLE = 3'h3,
      PAT_DOUBLE = 3'h4,
      PAT_TRIPLE = 3'h5,
      PAT_BLINK = 3'h6
   } fnsi_pat_e;

   // node states, one-hot
   typedef enum logic [6:0] {
      ST_INACTIVE = 7'h01,
      ST_FALLBACK = 7'h02,
      ST_SETUP1 = 7'h04,
      ST_SETUP2 = 7'h08,
      ST_ARMED = 7'h10,
      ST_RUNNING = 7'h20,
      ST_HALTED = 7'h40
   } fnsi_state_e;

   localparam fnsi_state_e STATE_RST = ST_INACTIVE;

   // inputs from outside the clock domain, carried through the synchroniser
   typedef struct packed {
      logic plain_eth;
      logic managing_station;
      logic config_ok;
      logic frame_seen;
      logic cycle_start_seen;
      logic cmd_next;
      logic cmd_halt;
      logic manager_failed;
      logic stop_error;
      logic [ERR_PHASES-1:0] err_long;
      logic [TMO_W-1:0] timeout_ms;
   } fnsi_in_s;

endpackage

// ===== rtl/fnsi_led_if.sv
// carrier between the state tracker and the led pattern generator
`timescale 1ns/1ps
interface fnsi_led_if;
   import fnsi_pkg::*;
   logic tick;
   fnsi_pat_e pat;
   logic stop_err;
   logic [ERR_PHASES-1:0] err_long;
   logic red_steady;
   logic green;
   logic red;

   modport drv (output tick, output pat, output stop_err, output err_long,
      output red_steady, input green, input red);
   modport gen (input tick, input pat, input stop_err, input err_long,
      input red_steady, output green, output red);
endinterface

// ===== rtl/fnsi_led_gen.sv
// green pattern and red error code generator for the dual status led
`timescale 1ns/1ps
module fnsi_led_gen
   import fnsi_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   fnsi_led_if.gen led
);

   typedef struct packed {
      fnsi_pat_e pat;
      logic [POS_W-1:0] pos;
      logic [2:0] step;
      logic [POS_W-1:0] ecnt;
      logic green;
      logic red;
   } fnsi_gen_s;

   fnsi_gen_s s_q;
   fnsi_gen_s s_d;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // wrap point of the position counter for each pattern
   function automatic logic [POS_W-1:0] period_of(input fnsi_pat_e p);
      if (p == PAT_FLICKER) begin
         return POS_W'(FLICKER_PERIOD_MS);
      end else if (p == PAT_BLINK) begin
         return POS_W'(BLINK_PERIOD_MS);
      end else begin
         return POS_W'(FLASH_PERIOD_MS);
      end
   endfunction

   // true while pulse k (0 based) of a flash train is lit
   function automatic logic in_pulse(input logic [POS_W-1:0] pos, input int k);
      return (pos >= POS_W'(k * FLASH_SLOT_MS)) &&
         (pos < POS_W'(k * FLASH_SLOT_MS + FLASH_ON_MS));
   endfunction

   function automatic logic green_of(input fnsi_pat_e p, input logic [POS_W-1:0] pos);
      case (p)
         PAT_ON: return 1'b1;
         PAT_FLICKER: return pos < POS_W'(FLICKER_ON_MS);
         PAT_BLINK: return pos < POS_W'(BLINK_ON_MS);
         PAT_SINGLE: return in_pulse(pos, 0);
         PAT_DOUBLE: return in_pulse(pos, 0) || in_pulse(pos, 1);
         PAT_TRIPLE: return in_pulse(pos, 0) || in_pulse(pos, 1) || in_pulse(pos, 2);
         default: return 1'b0;
      endcase
   endfunction

   // even steps light a phase, odd steps are gaps, the last one the pause
   function automatic logic [POS_W-1:0] step_len(input logic [2:0] st,
      input logic [ERR_PHASES-1:0] lng);
      if (!st[0]) begin
         return lng[2'(ERR_PHASES - 1) - st[2:1]] ? POS_W'(ERR_LONG_MS) :
            POS_W'(ERR_SHORT_MS);
      end else if (st == 3'h7) begin
         return POS_W'(ERR_PAUSE_MS);
      end else begin
         return POS_W'(ERR_GAP_MS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      // a new pattern restarts its frame so the first flash is whole
      if (led.pat != s_q.pat) begin
         s_d.pat = led.pat;
         s_d.pos = '0;
      end else if (led.tick) begin
         s_d.pos = (s_q.pos + 1'b1 >= period_of(s_q.pat)) ? '0 : s_q.pos + 1'b1;
      end
      s_d.green = green_of(s_q.pat, s_q.pos);
      // red: stop error code outranks the manager failure level
      if (!led.stop_err) begin
         s_d.step = '0;
         s_d.ecnt = '0;
         s_d.red = led.red_steady;
      end else begin
         if (led.tick) begin
            if (s_q.ecnt + 1'b1 >= step_len(s_q.step, led.err_long)) begin
               s_d.ecnt = '0;
               s_d.step = s_q.step + 1'b1; // wraps to repeat the code
            end else begin
               s_d.ecnt = s_q.ecnt + 1'b1;
            end
         end
         s_d.red = !s_q.step[0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{pat: PAT_OFF, pos: '0, step: '0, ecnt: '0, green: 1'b0, red: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign led.green = s_q.green;
   assign led.red = s_q.red;

endmodule // fnsi_led_gen

// ===== rtl/fnsi_top.sv
// fieldbus node state tracker and dual status led driver
// Overview of operation
// - dual led, green and red driven apart; meaning follows the operating mode
// - plain ethernet configuration holds green steadily lit
// - green dark in the inactive state, except in plain ethernet mode where it stays lit
// - managing station, no frame before timeout: go to setup stage one
// - managing station seeing foreign traffic before timeout stays inactive
// - controlled station, no frame before timeout: go to network fallback
// - controlled station seeing traffic before timeout: go to setup stage one
// - fallback state flickers green at about 10 Hz
// - managing station leaves fallback only through reset
// - controlled station in fallback goes to setup one on traffic
// - setup stage one shows single flash at about 1 Hz
// - managing station in setup one runs reduced cycle, no cyclic traffic
// - controlled station in setup one takes config, moves on cycle start
// - controlled station in setup one lights red on manager failure
// - setup stage two shows double flash at about 1 Hz
// - managing station in setup two runs cyclic, configures, ignores inputs
// - armed state, entered by command, shows triple flash at about 1 Hz
// - running state: green steady, mapping applied, cyclic data evaluated
// - halted: 2.5 Hz blink, io suppressed, controlled station only by command
// - stop error: four short or long red phases repeated with pause
`timescale 1ns/1ps
module fnsi_top
   import fnsi_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PLAIN_ETH,
   input wire logic MANAGING_STATION,
   input wire logic CONFIG_OK,
   input wire logic FRAME_SEEN,
   input wire logic CYCLE_START_SEEN,
   input wire logic CMD_NEXT,
   input wire logic CMD_HALT,
   input wire logic MANAGER_FAILED,
   input wire logic STOP_ERROR,
   input wire logic [ERR_PHASES-1:0] ERR_LONG,
   input wire logic [TMO_W-1:0] TIMEOUT_MS,
   output logic LED_GREEN,
   output logic LED_RED,
   output logic [6:0] NODE_STATE,
   output logic MANAGER_BLOCKED,
   output logic REDUCED_CYCLE,
   output logic CYCLIC_COMM,
   output logic CONFIG_ACCEPT,
   output logic EVAL_CYCLIC,
   output logic MAPPING_ACTIVE,
   output logic IO_SUPPRESS
);

   typedef struct packed {
      fnsi_in_s sync1;
      fnsi_in_s sync2;
      logic next_prev;
      logic halt_prev;
      logic [MS_CNT_W-1:0] tick_cnt;
      logic tick;
      logic [TMO_W-1:0] tmo_cnt;
      fnsi_state_e state;
      logic mgr_blocked;
      logic led_green;
      logic led_red;
      logic reduced_cycle;
      logic cyclic_comm;
      logic config_accept;
      logic eval_cyclic;
      logic mapping_active;
      logic io_suppress;
   } fnsi_top_s;

   fnsi_top_s s_q;
   fnsi_top_s s_d;
   fnsi_in_s pins;
   fnsi_in_s in;
   logic next_rise;
   logic halt_rise;
   logic tmo_hit;

   fnsi_led_if led_bus ();

   ////////////////////////////////////////////////////////////////////////////
   // inputs

   // gather the pins for the synchroniser
   assign pins = '{
      plain_eth: PLAIN_ETH,
      managing_station: MANAGING_STATION,
      config_ok: CONFIG_OK,
      frame_seen: FRAME_SEEN,
      cycle_start_seen: CYCLE_START_SEEN,
      cmd_next: CMD_NEXT,
      cmd_halt: CMD_HALT,
      manager_failed: MANAGER_FAILED,
      stop_error: STOP_ERROR,
      err_long: ERR_LONG,
      timeout_ms: TIMEOUT_MS
   };

   // only the second stage is read below
   assign in = s_q.sync2;
   assign next_rise = in.cmd_next && !s_q.next_prev;
   assign halt_rise = in.cmd_halt && !s_q.halt_prev;
   // a zero timeout expires on the first tick rather than never
   assign tmo_hit = s_q.tick && (s_q.tmo_cnt + 1'b1 >= in.timeout_ms);

   ////////////////////////////////////////////////////////////////////////////
   // led pattern selection

   function automatic fnsi_pat_e pat_of(input fnsi_state_e st, input logic eth);
      if (eth) begin
         return PAT_ON;
      end
      case (st)
         ST_FALLBACK: return PAT_FLICKER;
         ST_SETUP1: return PAT_SINGLE;
         ST_SETUP2: return PAT_DOUBLE;
         ST_ARMED: return PAT_TRIPLE;
         ST_RUNNING: return PAT_ON;
         ST_HALTED: return PAT_BLINK;
         default: return PAT_OFF;
      endcase
   endfunction

   // green and red are fed separately to the generator
   assign led_bus.tick = s_q.tick;
   assign led_bus.pat = pat_of(s_q.state, in.plain_eth);
   assign led_bus.stop_err = in.stop_error;
   assign led_bus.err_long = in.err_long;
   // manager failure is only meaningful for a controlled station in setup one, setup two or armed
   assign led_bus.red_steady = in.manager_failed && !in.managing_station &&
      (s_q.state == ST_SETUP1 || s_q.state == ST_SETUP2 ||
      s_q.state == ST_ARMED);

   fnsi_led_gen u_led_gen (
      .clk(CLK),
      .rst_b(RST_B),
      .led(led_bus.gen)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      s_d.sync1 = pins;
      s_d.sync2 = s_q.sync1;
      s_d.next_prev = in.cmd_next;
      s_d.halt_prev = in.cmd_halt;

      // millisecond tick shared by the timeout and the led generator
      s_d.tick = 1'b0;
      if (s_q.tick_cnt >= MS_CNT_W'(MS_CYCLES_P - 1)) begin
         s_d.tick_cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 1'b1;
      end

      // timeout only runs in the inactive state and restarts on leaving it
      if (s_q.state != ST_INACTIVE) begin
         s_d.tmo_cnt = '0;
      end else if (s_q.tick && !tmo_hit) begin
         s_d.tmo_cnt = s_q.tmo_cnt + 1'b1;
      end

      case (s_q.state)
         ST_INACTIVE: begin
            // plain ethernet mode and a bad configuration park the node here
            if (in.plain_eth || !in.config_ok || s_q.mgr_blocked) begin
               s_d.state = ST_INACTIVE;
            end else if (in.managing_station) begin
               // another manager is already talking: never start, stay parked
               if (in.frame_seen) begin
                  s_d.mgr_blocked = 1'b1;
               end else if (tmo_hit) begin
                  s_d.state = ST_SETUP1;
               end
            end else begin
               // controlled station: traffic joins, silence falls back
               if (in.frame_seen) begin
                  s_d.state = ST_SETUP1;
               end else if (tmo_hit) begin
                  s_d.state = ST_FALLBACK;
               end
            end
         end
         ST_FALLBACK: begin
            // a managing station has no way out short of a reset
            if (!in.managing_station && in.frame_seen) begin
               s_d.state = ST_SETUP1;
            end
         end
         ST_SETUP1: begin
            // manager moves on by command, controlled station on cycle start
            if (in.managing_station) begin
               if (next_rise) begin
                  s_d.state = ST_SETUP2;
               end
            end else if (in.cycle_start_seen) begin
               s_d.state = ST_SETUP2;
            end
         end
         ST_SETUP2: begin
            // halting is a manager's command, so refused in that role
            if (next_rise) begin
               s_d.state = ST_ARMED;
            end else if (halt_rise && !in.managing_station) begin
               s_d.state = ST_HALTED;
            end
         end
         ST_ARMED: begin
            // armed waits for the go command
            if (next_rise) begin
               s_d.state = ST_RUNNING;
            end else if (halt_rise && !in.managing_station) begin
               s_d.state = ST_HALTED;
            end
         end
         ST_RUNNING: begin
            // running is left only by a halt command
            if (halt_rise && !in.managing_station) begin
               s_d.state = ST_HALTED;
            end
         end
         ST_HALTED: begin
            // halted is left only by the manager's command, back to setup two
            if (next_rise) begin
               s_d.state = ST_SETUP2;
            end
         end
         default: begin
            // an illegal code recovers to a known, quiet state
            s_d.state = ST_INACTIVE;
         end
      endcase

      // role-dependent activity, registered so the outputs come from flops
      // only a manager runs the reduced cycle, and only in setup one
      s_d.reduced_cycle = in.managing_station && s_q.state == ST_SETUP1;
      // cyclic traffic from setup two on, never while halted
      s_d.cyclic_comm = s_q.state == ST_SETUP2 || s_q.state == ST_ARMED ||
         s_q.state == ST_RUNNING;
      s_d.config_accept = in.managing_station ? s_q.state == ST_SETUP2 :
         s_q.state == ST_SETUP1 || s_q.state == ST_SETUP2;
      // inputs are evaluated and mapped only once running
      s_d.eval_cyclic = s_q.state == ST_RUNNING;
      s_d.mapping_active = s_q.state == ST_RUNNING;
      s_d.io_suppress = s_q.state == ST_HALTED;
      // one more flop so the led pins come straight from a register
      s_d.led_green = led_bus.green;
      s_d.led_red = led_bus.red;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_q <= '{
            sync1: '0,
            sync2: '0,
            next_prev: 1'b0,
            halt_prev: 1'b0,
            tick_cnt: '0,
            tick: 1'b0,
            tmo_cnt: '0,
            state: STATE_RST,
            mgr_blocked: 1'b0,
            led_green: 1'b0,
            led_red: 1'b0,
            reduced_cycle: 1'b0,
            cyclic_comm: 1'b0,
            config_accept: 1'b0,
            eval_cyclic: 1'b0,
            mapping_active: 1'b0,
            io_suppress: 1'b0
         };
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // every output is a field of the registered state
   assign LED_GREEN = s_q.led_green;
   assign LED_RED = s_q.led_red;
   assign NODE_STATE = s_q.state;
   assign MANAGER_BLOCKED = s_q.mgr_blocked;
   assign REDUCED_CYCLE = s_q.reduced_cycle;
   assign CYCLIC_COMM = s_q.cyclic_comm;
   assign CONFIG_ACCEPT = s_q.config_accept;
   assign EVAL_CYCLIC = s_q.eval_cyclic;
   assign MAPPING_ACTIVE = s_q.mapping_active;
   assign IO_SUPPRESS = s_q.io_suppress;

endmodule // fnsi_top

// ===== bench/fnsi_top_monitor.sv
// assertion checker on the ports of the node state indicator
`timescale 1ns/1ps
module fnsi_top_monitor (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PLAIN_ETH,
   input wire logic MANAGING_STATION,
   input wire logic CONFIG_OK,
   input wire logic FRAME_SEEN,
   input wire logic MANAGER_FAILED,
   input wire logic STOP_ERROR,
   input wire logic LED_GREEN,
   input wire logic LED_RED,
   input wire logic [6:0] NODE_STATE,
   input wire logic MANAGER_BLOCKED,
   input wire logic REDUCED_CYCLE,
   input wire logic CYCLIC_COMM,
   input wire logic EVAL_CYCLIC,
   input wire logic MAPPING_ACTIVE,
   input wire logic IO_SUPPRESS
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////////////////////////
   // led levels; repetitions leave room for the two sync flops
   plain_green_a: assert property (PLAIN_ETH [*8] |-> LED_GREEN && NODE_STATE == 7'h01)
      else $error("green not steady in plain ethernet mode");
   inact_dark_a: assert property ((NODE_STATE == 7'h01 && !PLAIN_ETH) [*8] |-> !LED_GREEN)
      else $error("green lit while inactive");
   mgr_red_a: assert property ((!MANAGING_STATION && NODE_STATE == 7'h04 && MANAGER_FAILED
      && !STOP_ERROR) [*7] |-> LED_RED)
      else $error("red dark on manager failure in setup one");
   ////////////////////////////////////////////////////////////
   // transitions and activity outputs, which lag the state by one cycle
   frame_cn_a: assert property ($rose(FRAME_SEEN) && !MANAGING_STATION && CONFIG_OK
      && !PLAIN_ETH && NODE_STATE inside {7'h01, 7'h02} |-> ##[1:8] NODE_STATE == 7'h04)
      else $error("controlled station missed setup one on traffic");
   mgr_block_a: assert property (MANAGER_BLOCKED |-> NODE_STATE == 7'h01)
      else $error("blocked managing station left inactive");
   reduced_cycle_a: assert property (MANAGING_STATION && NODE_STATE == 7'h04
      |=> REDUCED_CYCLE && !CYCLIC_COMM)
      else $error("managing setup one not in reduced cycle");
   setup_two_a: assert property (NODE_STATE == 7'h08 |=> CYCLIC_COMM && !EVAL_CYCLIC)
      else $error("setup two cyclic flags wrong");
   running_out_a: assert property (NODE_STATE == 7'h20 |=> EVAL_CYCLIC && MAPPING_ACTIVE)
      else $error("running state flags wrong");
   halt_io_a: assert property (NODE_STATE == 7'h40 |=> IO_SUPPRESS && !CYCLIC_COMM)
      else $error("halted state does not suppress io");
   mgr_nohalt_a: assert property (MANAGING_STATION |-> NODE_STATE != 7'h40)
      else $error("managing station halted");
endmodule // fnsi_top_monitor

bind fnsi_top fnsi_top_monitor u_mon (.*);

// ===== bench/fnsi_node_model.sv
// stand-in for the other fieldbus nodes on the network
`timescale 1ns/1ps
module fnsi_node_model (
   input wire logic clk,
   input wire logic send_frame,
   input wire logic send_soc,
   output logic frame_seen,
   output logic cycle_start_seen
);
   logic [2:0] frame_q = 3'h0;
   logic [2:0] soc_q = 3'h0;
   // four cycle events, so the two sync stages never miss one
   always_ff @(posedge clk) begin
      frame_q <= send_frame ? 3'h4 : (frame_q == 3'h0) ? 3'h0 : frame_q - 3'h1;
      soc_q <= send_soc ? 3'h4 : (soc_q == 3'h0) ? 3'h0 : soc_q - 3'h1;
   end
   // line idles low between events: no traffic seen
   assign frame_seen = frame_q != 3'h0;
   assign cycle_start_seen = soc_q != 3'h0;
endmodule // fnsi_node_model

// ===== bench/fieldbus_node_state_indicator_test.sv
// self-checking bench for the node state indicator
`timescale 1ns/1ps
module fieldbus_node_state_indicator_test
   import fnsi_pkg::*;
;
   logic CLK, RST_B, PLAIN_ETH, MANAGING_STATION, CONFIG_OK, FRAME_SEEN, CYCLE_START_SEEN;
   logic CMD_NEXT, CMD_HALT, MANAGER_FAILED, STOP_ERROR;
   logic [ERR_PHASES-1:0] ERR_LONG;
   logic [TMO_W-1:0] TIMEOUT_MS;
   logic LED_GREEN, LED_RED, MANAGER_BLOCKED, REDUCED_CYCLE, CYCLIC_COMM;
   logic CONFIG_ACCEPT, EVAL_CYCLIC, MAPPING_ACTIVE, IO_SUPPRESS;
   logic [6:0] NODE_STATE;
   logic send_frame, send_soc;
   int fail_count, compares, hi, ri, cyc;

   // ms tick of 4 cycles keeps the 1 s flash frame at 4000 cycles
   fnsi_top #(.MS_CYCLES_P(4)) dut (.*);
   fnsi_node_model peer (.clk(CLK), .send_frame(send_frame), .send_soc(send_soc),
      .frame_seen(FRAME_SEEN), .cycle_start_seen(CYCLE_START_SEEN));

   // 200 MHz system clock
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////
   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic chk_vec(input string n, input logic [6:0] e, input logic [6:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_cnt(input string n, input int e, input int g);
      compares++;
      if (g != e) begin
         fail_count++;
         $display("Error %s exp %0d got %0d", n, e, g);
      end
   endtask
   // bounded wait for a state, then compare it
   task automatic wait_st(input logic [6:0] e, input int lim);
      cyc = 0;
      while (NODE_STATE !== e && cyc < lim) begin
         step(1);
         cyc++;
      end
      chk_vec("node_state", e, NODE_STATE);
   endtask
   // counts lit cycles and rising edges over a window of n cycles
   task automatic meas(input int n, input bit red);
      logic p, v;
      hi = 0;
      ri = 0;
      p = red ? LED_RED : LED_GREEN;
      repeat (n) begin
         step(1);
         v = red ? LED_RED : LED_GREEN;
         if (v === 1'b1) hi++;
         if (v === 1'b1 && p !== 1'b1) ri++;
         p = v;
      end
   endtask
   // commands stay high and low three cycles each, past the synchroniser
   task automatic pulse(input bit halt);
      if (halt) CMD_HALT = 1'b1;
      else CMD_NEXT = 1'b1;
      step(3);
      CMD_HALT = 1'b0;
      CMD_NEXT = 1'b0;
      step(3);
   endtask
   task automatic frame(input bit soc);
      if (soc) send_soc = 1'b1;
      else send_frame = 1'b1;
      step(1);
      send_soc = 1'b0;
      send_frame = 1'b0;
   endtask
   // role is only changed while reset is held
   task automatic do_reset(input logic mgr);
      RST_B = 1'b0;
      MANAGING_STATION = mgr;
      step(6);
      chk_vec("reset_state", 7'h01, NODE_STATE);
      chk_bit("reset_green", 1'b0, LED_GREEN);
      RST_B = 1'b1;
      step(1);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_plain();
      do_reset(1'b0);
      PLAIN_ETH = 1'b1;
      step(10);
      chk_bit("plain_green", 1'b1, LED_GREEN);
      chk_vec("plain_state", 7'h01, NODE_STATE);
      PLAIN_ETH = 1'b0;
      step(6);
      chk_bit("inactive_green", 1'b0, LED_GREEN);
      $display("done plain");
   endtask
   task automatic t_cn_fallback();
      do_reset(1'b0);
      wait_st(7'h02, 200);
      chk_bit("cn_timeout_span", 1'b1, cyc >= 8 && cyc <= 24);
      step(10);
      meas(400, 1'b0);
      chk_cnt("flicker_on", 200, hi);
      chk_cnt("flicker_rises", 1, ri);
      $display("done cn_fallback");
   endtask
   task automatic t_cn_setup();
      frame(1'b0);
      wait_st(7'h04, 20);
      step(2);
      chk_bit("config_accept", 1'b1, CONFIG_ACCEPT);
      MANAGER_FAILED = 1'b1;
      step(10);
      chk_bit("manager_fail_red", 1'b1, LED_RED);
      MANAGER_FAILED = 1'b0;
      step(10);
      meas(4000, 1'b0);
      chk_cnt("single_on", 600, hi);
      chk_cnt("single_rises", 1, ri);
      frame(1'b1);
      wait_st(7'h08, 20);
      step(10);
      meas(4000, 1'b0);
      chk_cnt("double_on", 1200, hi);
      chk_cnt("double_rises", 2, ri);
      $display("done cn_setup");
   endtask
   task automatic t_cn_halt();
      pulse(1'b1);
      wait_st(7'h40, 20);
      step(1);
      chk_bit("io_suppress", 1'b1, IO_SUPPRESS);
      step(10);
      meas(1600, 1'b0);
      chk_cnt("blink_on", 800, hi);
      chk_cnt("blink_rises", 1, ri);
      pulse(1'b0);
      wait_st(7'h08, 20);
      pulse(1'b0);
      wait_st(7'h10, 20);
      step(10);
      meas(4000, 1'b0);
      chk_cnt("triple_on", 1800, hi);
      chk_cnt("triple_rises", 3, ri);
      pulse(1'b0);
      wait_st(7'h20, 20);
      step(2);
      chk_bit("eval_cyclic", 1'b1, EVAL_CYCLIC);
      chk_bit("mapping", 1'b1, MAPPING_ACTIVE);
      meas(100, 1'b0);
      chk_cnt("running_on", 100, hi);
      $display("done cn_halt");
   endtask
   // first phase long, then three short: 1050 ms lit in a 3950 ms code
   task automatic t_stop();
      STOP_ERROR = 1'b1;
      step(10);
      meas(15800, 1'b1);
      chk_cnt("code_on", 4200, hi);
      chk_cnt("code_phases", 4, ri);
      STOP_ERROR = 1'b0;
      $display("done stop");
   endtask
   task automatic t_cn_early();
      do_reset(1'b0);
      frame(1'b0);
      wait_st(7'h04, 20);
      // a faulty configuration parks the node dark, well past the timeout
      CONFIG_OK = 1'b0;
      do_reset(1'b0);
      step(40);
      chk_vec("bad_config_state", 7'h01, NODE_STATE);
      chk_bit("bad_config_green", 1'b0, LED_GREEN);
      CONFIG_OK = 1'b1;
      $display("done cn_early");
   endtask
   task automatic t_mn();
      TIMEOUT_MS = 16'h0006;
      do_reset(1'b1);
      wait_st(7'h04, 200);
      chk_bit("mn_timeout_span", 1'b1, cyc >= 20 && cyc <= 36);
      step(1);
      chk_bit("reduced_cycle", 1'b1, REDUCED_CYCLE);
      chk_bit("no_cyclic", 1'b0, CYCLIC_COMM);
      pulse(1'b0);
      wait_st(7'h08, 20);
      step(1);
      chk_bit("mn_cyclic", 1'b1, CYCLIC_COMM);
      chk_bit("mn_no_eval", 1'b0, EVAL_CYCLIC);
      pulse(1'b1);
      step(10);
      chk_vec("mn_halt_refused", 7'h08, NODE_STATE);
      $display("done mn");
   endtask
   task automatic t_mn_block();
      do_reset(1'b1);
      frame(1'b0);
      step(40);
      chk_bit("mn_blocked", 1'b1, MANAGER_BLOCKED);
      chk_vec("mn_stays_inactive", 7'h01, NODE_STATE);
      $display("done mn_block");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      {PLAIN_ETH, CMD_NEXT, CMD_HALT, MANAGER_FAILED, STOP_ERROR, send_frame, send_soc} = 7'h00;
      CONFIG_OK = 1'b1;
      ERR_LONG = 4'h8;
      TIMEOUT_MS = 16'h0003;
      RST_B = 1'b0;
      MANAGING_STATION = 1'b0;
      fail_count = 0;
      compares = 0;
      t_plain();
      t_cn_fallback();
      t_cn_setup();
      t_cn_halt();
      t_stop();
      t_cn_early();
      t_mn();
      t_mn_block();
      end_of_test();
   end
   // watchdog well past the roughly 30000 cycles the tests need
   initial begin
      repeat (100000) @(posedge CLK);
      fail_count++;
      end_of_test();
   end
endmodule // fieldbus_node_state_indicator_test
